// ==== hdl/ufeam_defines.vh ====
// Constants for the framing-error and address-match receive extension.
// Assumes an 8-bit register port with byte offsets as printed.
`ifndef UFEAM_DEFINES_VH
`define UFEAM_DEFINES_VH
`define UFEAM_OFF_CTL0     8'h98
`define UFEAM_OFF_BUF0     8'h99
`define UFEAM_OFF_PWR      8'h87
`define UFEAM_OFF_OWN0     8'hA9
`define UFEAM_OFF_OWN1     8'hAA
`define UFEAM_OFF_MASK0    8'hB9
`define UFEAM_OFF_MASK1    8'hBA
`define UFEAM_OFF_CTL1     8'hC0
`define UFEAM_OFF_BUF1     8'hC1
`define UFEAM_BIT_MODE_ERR 7
`define UFEAM_BIT_MODE_LO  6
`define UFEAM_BIT_MATCH_EN 5
`define UFEAM_BIT_RX_EN    4
`define UFEAM_BIT_TX_NINTH 3
`define UFEAM_BIT_RX_NINTH 2
`define UFEAM_BIT_TX_DONE  1
`define UFEAM_BIT_RX_DONE  0
`define UFEAM_BIT_VIEW     6
`define UFEAM_RST_MASK     8'h00
`define UFEAM_RST_ADDR     8'h00
`define UFEAM_RST_CTL      8'h00
`define UFEAM_RST_PWR      8'h00
`define UFEAM_BAUD_DIV     16'd21
`define UFEAM_OVERSAMPLE   5'd16
`endif

// ==== hdl/ufeam_baud.v ====
// Baud tick divider: one-cycle pulse at sixteen times the bit rate.
// Assumes a single clock domain.
`include "ufeam_defines.vh"
`default_nettype none
module ufeam_baud #(
  parameter [15:0] DIV = `UFEAM_BAUD_DIV
) (
  input  wire        clk,
  input  wire        rst_n,
  output reg         tick
);
  reg [15:0] cnt_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_r == DIV - 16'd1) begin
      cnt_r <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'd1;
      tick  <= 1'b0;
    end
  end
endmodule // ufeam_baud
`default_nettype wire

// ==== hdl/ufeam_rx.v ====
// Oversampling serial receiver with 3-sample majority vote.
// Assumes rxd already synchronous; ninth-bit frames when nine_bit is high.
`default_nettype none
module ufeam_rx (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       tick,
  input  wire       rxd,
  input  wire       en,
  input  wire       nine_bit,
  output reg        ninth_done,
  output reg        stop_done,
  output reg  [7:0] data,
  output reg        bit9,
  output reg        stop_bit
);
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_START = 2'd1;
  localparam [1:0] S_BITS = 2'd2;
  reg [1:0] st_r;
  reg [3:0] ph_r;
  reg [3:0] idx_r;
  reg [2:0] smp_r;
  reg       rxd_d_r;
  wire      vote = (smp_r[0] & smp_r[1]) | (smp_r[1] & smp_r[2]) | (smp_r[0] & smp_r[2]);
  wire [3:0] last = nine_bit ? 4'd10 : 4'd9;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_IDLE;
      ph_r <= 4'h0;
      idx_r <= 4'h0;
      smp_r <= 3'h7;
      rxd_d_r <= 1'b1;
      ninth_done <= 1'b0;
      stop_done <= 1'b0;
      data <= 8'h00;
      bit9 <= 1'b0;
      stop_bit <= 1'b1;
    end else begin
      ninth_done <= 1'b0;
      stop_done <= 1'b0;
      rxd_d_r <= rxd;
      case (st_r)
        S_IDLE: begin
          if (en && rxd_d_r && !rxd) begin
            st_r <= S_START;
            ph_r <= 4'h0;
            // Wraps to zero at the end of the start bit, so data bit 0 is index 0.
            idx_r <= 4'hF;
          end
        end
        default: begin
          if (tick) begin
            ph_r <= ph_r + 4'd1;
            // Samples on the 7th, 8th and 9th oversample ticks.
            if (ph_r >= 4'd6 && ph_r <= 4'd8)
              smp_r <= {smp_r[1:0], rxd};
            if (ph_r == 4'd9) begin
              if (st_r == S_START) begin
                st_r <= vote ? S_IDLE : S_BITS;
              end else begin
                if (idx_r < 4'd8)
                  data <= {vote, data[7:1]};
                if (idx_r == 4'd8 && nine_bit) begin
                  bit9 <= vote;
                  ninth_done <= 1'b1;
                end
                if (idx_r == last - 4'd1) begin
                  stop_bit <= vote;
                  stop_done <= 1'b1;
                  st_r <= S_IDLE;
                end
              end
            end
            if (ph_r == 4'd15 && st_r == S_BITS)
              idx_r <= idx_r + 4'd1;
          end
        end
      endcase
    end
  end
endmodule // ufeam_rx
`default_nettype wire

// ==== hdl/ufeam_top.v ====
// Receive extension for two serial ports: framing error and address match.
// Assumes an 8-bit register port, read data one cycle after the read strobe.
//
// Function
// - A received word without a valid stop bit sets that port's framing error flag.
// - The framing error flag sits at bit 7 of each port's serial control register.
// - With the view select bit (power control bit 6) at 1, bit 7 reaches the error flag.
// - Mode bit and error flag are stored apart; the view select only picks which is reached.
// - The error flag is sticky; only a software write of zero clears it.
// - Address recognition applies only in the two 9-bit modes, keyed by the ninth bit.
// - A ninth bit of 1 with match enable set marks an address to compare.
// - With matching active, a non-matching address never sets the receive done flag.
// - Each port has its own own-address and mask registers at A9h/AAh and B9h/BAh.
// - Mask bits at 0 make the matching own-address bits don't-care.
// - The broadcast address, own address OR mask, also matches, as a parameter option.
// - Recognition is on only with match enable set; masks reset to 00h so every address matches.
// - In 9-bit modes loading is decided at mid ninth bit on receive flag and ninth bit.
// - In 10-bit mode with match enable set a word loads only with a stop bit of 1.
//
// Decided for this implementation: the strobed register port.
`include "ufeam_defines.vh"
`default_nettype none
module ufeam_top #(
  parameter        BROADCAST = 1,
  parameter [15:0] BAUD_DIV  = `UFEAM_BAUD_DIV
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  input  wire       rxd0,
  input  wire       rxd1,
  output reg        rx_done0,
  output reg        rx_done1
);
  function match;
    input [7:0] rx;
    input [7:0] own;
    input [7:0] msk;
    input       bcast;
    reg   [7:0] bc;
    begin
      bc    = own | msk;
      match = (((rx ^ own) & msk) == 8'h00)
              || (bcast && (((rx ^ bc) & bc) == 8'h00));
    end
  endfunction

  wire tick;
  ufeam_baud #(.DIV(BAUD_DIV)) u_baud (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick)
  );

  reg  [7:0] pwr_ctl_r;
  reg  [7:0] scon_r    [0:1];
  reg        frm_err_r [0:1];
  reg  [7:0] rx_buf_r  [0:1];
  reg  [7:0] own_r     [0:1];
  reg  [7:0] mask_r    [0:1];
  wire       view = pwr_ctl_r[`UFEAM_BIT_VIEW];
  wire       ninth_done [0:1];
  wire       stop_done  [0:1];
  wire [7:0] rx_data    [0:1];
  wire       rx_bit9    [0:1];
  wire       rx_stop    [0:1];

  ufeam_rx u_rx0 (
    .clk        (clk),
    .rst_n      (rst_n),
    .tick       (tick),
    .rxd        (rxd0),
    .en         (scon_r[0][`UFEAM_BIT_RX_EN]),
    .nine_bit   (scon_r[0][`UFEAM_BIT_MODE_ERR]),
    .ninth_done (ninth_done[0]),
    .stop_done  (stop_done[0]),
    .data       (rx_data[0]),
    .bit9       (rx_bit9[0]),
    .stop_bit   (rx_stop[0])
  );
  ufeam_rx u_rx1 (
    .clk        (clk),
    .rst_n      (rst_n),
    .tick       (tick),
    .rxd        (rxd1),
    .en         (scon_r[1][`UFEAM_BIT_RX_EN]),
    .nine_bit   (scon_r[1][`UFEAM_BIT_MODE_ERR]),
    .ninth_done (ninth_done[1]),
    .stop_done  (stop_done[1]),
    .data       (rx_data[1]),
    .bit9       (rx_bit9[1]),
    .stop_bit   (rx_stop[1])
  );

  // Load decision per port; 9-bit modes decide on the ninth bit's data word.
  reg [1:0] load;
  reg [1:0] load_bit;
  integer   p;
  always @* begin
    load     = 2'b00;
    load_bit = 2'b00;
    for (p = 0; p < 2; p = p + 1) begin
      if (scon_r[p][`UFEAM_BIT_MODE_ERR]) begin
        // mid-ninth-bit decision; only 9-bit frames are matched.
        if (ninth_done[p] && !scon_r[p][`UFEAM_BIT_RX_DONE]) begin
          if (!scon_r[p][`UFEAM_BIT_MATCH_EN])
            load[p] = 1'b1;
          else if (rx_bit9[p] && match(rx_data[p], own_r[p], mask_r[p], BROADCAST != 0))
            load[p] = 1'b1;
        end
        load_bit[p] = rx_bit9[p];
      end else begin
        if (stop_done[p] && !scon_r[p][`UFEAM_BIT_RX_DONE]
            && (!scon_r[p][`UFEAM_BIT_MATCH_EN] || rx_stop[p]))
          load[p] = 1'b1;
        load_bit[p] = rx_stop[p];
      end
    end
  end

  // Register writes and receiver updates.
  wire [1:0] wr_scon = {wr && addr == `UFEAM_OFF_CTL1, wr && addr == `UFEAM_OFF_CTL0};
  integer q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ctl_r <= `UFEAM_RST_PWR;
      for (q = 0; q < 2; q = q + 1) begin
        scon_r[q]    <= `UFEAM_RST_CTL;
        frm_err_r[q] <= 1'b0;
        rx_buf_r[q]  <= 8'h00;
        own_r[q]     <= `UFEAM_RST_ADDR;
        mask_r[q]    <= `UFEAM_RST_MASK;
      end
    end else begin
      if (wr) begin
        if (addr == `UFEAM_OFF_PWR)
          pwr_ctl_r <= wdata;
        else if (addr == `UFEAM_OFF_OWN0)
          own_r[0] <= wdata;
        else if (addr == `UFEAM_OFF_OWN1)
          own_r[1] <= wdata;
        else if (addr == `UFEAM_OFF_MASK0)
          mask_r[0] <= wdata;
        else if (addr == `UFEAM_OFF_MASK1)
          mask_r[1] <= wdata;
      end
      for (q = 0; q < 2; q = q + 1) begin
        if (wr_scon[q]) begin
          // bit 7 write goes to one store only.
          if (view)
            scon_r[q] <= {scon_r[q][7], wdata[6:0]};
          else
            scon_r[q] <= wdata;
          if (view && !wdata[`UFEAM_BIT_MODE_ERR])
            frm_err_r[q] <= 1'b0;
        end
        // Hardware set wins over a same-cycle software clear.
        if (stop_done[q] && !rx_stop[q])
          frm_err_r[q] <= 1'b1;
        if (load[q]) begin
          rx_buf_r[q] <= rx_data[q];
          scon_r[q][`UFEAM_BIT_RX_NINTH] <= load_bit[q];
          scon_r[q][`UFEAM_BIT_RX_DONE]  <= 1'b1;
        end
      end
    end
  end

  // Read port: data stand one cycle after the strobe, unmapped reads as zero.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata    <= 8'h00;
      rx_done0 <= 1'b0;
      rx_done1 <= 1'b0;
    end else begin
      rx_done0 <= scon_r[0][`UFEAM_BIT_RX_DONE];
      rx_done1 <= scon_r[1][`UFEAM_BIT_RX_DONE];
      if (!rd)
        rdata <= 8'h00;
      else if (addr == `UFEAM_OFF_CTL0)
        rdata <= {view ? frm_err_r[0] : scon_r[0][7], scon_r[0][6:0]};
      else if (addr == `UFEAM_OFF_CTL1)
        rdata <= {view ? frm_err_r[1] : scon_r[1][7], scon_r[1][6:0]};
      else if (addr == `UFEAM_OFF_BUF0)
        rdata <= rx_buf_r[0];
      else if (addr == `UFEAM_OFF_BUF1)
        rdata <= rx_buf_r[1];
      else if (addr == `UFEAM_OFF_PWR)
        rdata <= pwr_ctl_r;
      else if (addr == `UFEAM_OFF_OWN0)
        rdata <= own_r[0];
      else if (addr == `UFEAM_OFF_OWN1)
        rdata <= own_r[1];
      else if (addr == `UFEAM_OFF_MASK0)
        rdata <= mask_r[0];
      else if (addr == `UFEAM_OFF_MASK1)
        rdata <= mask_r[1];
      else
        rdata <= 8'h00;
    end
  end
endmodule // ufeam_top
`default_nettype wire

// ==== verif/ufeam_sva.sv ====
// Checker for ufeam_top: register reads and receive done flags.
// Assumes one clock and sight of the top module's ports only.
`default_nettype none
module ufeam_sva #(
  parameter [15:0] BAUD_DIV = 16'd1
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       rxd0,
  input wire logic       rxd1,
  input wire logic       rx_done0,
  input wire logic       rx_done1
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic        view_r;
  logic        mode_r;
  logic [15:0] quiet_r;
  wire         s0w = wr && addr == 8'h98;
  wire         s1w = wr && addr == 8'hC0;
  wire         known = addr inside {8'h87, 8'h98, 8'h99, 8'hA9, 8'hAA, 8'hB9, 8'hBA,
                                    8'hC0, 8'hC1};
  // The mode bit only changes through writes made with the error view off.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      view_r  <= 1'b0;
      mode_r  <= 1'b0;
      quiet_r <= 16'h0000;
    end else begin
      if (wr && addr == 8'h87) view_r <= wdata[6];
      if (s0w && !view_r) mode_r <= wdata[7];
      quiet_r <= rxd0 ? quiet_r + 16'h0001 : 16'h0000;
    end
  end
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property ($past(rd && !known) |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reg_readback: assert property ((wr && addr inside {8'hA9, 8'hAA, 8'hB9, 8'hBA}) ##1
    (rd && $stable(addr)) |=> rdata == $past(wdata, 2)) else $error("address register lost");
  a_mode_view: assert property ($past(rd && addr == 8'h98 && !view_r)
    |-> rdata[7] == $past(mode_r)) else $error("mode bit corrupted");
  a_view_read: assert property ($past(rd && addr == 8'h87) |-> rdata[6] == $past(view_r))
    else $error("view select readback wrong");
  a_done0_hold: assert property (rx_done0 && !s0w && !$past(s0w) |=> rx_done0)
    else $error("port 0 done flag dropped");
  a_done1_hold: assert property (rx_done1 && !s1w && !$past(s1w) |=> rx_done1)
    else $error("port 1 done flag dropped");
  a_done_cause: assert property ($rose(rx_done0) |-> quiet_r < 16'd192 * BAUD_DIV)
    else $error("port 0 done without a frame");
  c_done0: cover property ($rose(rx_done0));
  c_done1: cover property ($rose(rx_done1) && !rxd1);
  c_fe_seen: cover property ($past(rd && addr == 8'h98 && view_r) && rdata[7]);
endmodule // ufeam_sva
bind ufeam_top ufeam_sva #(.BAUD_DIV(BAUD_DIV)) u_sva (.clk, .rst_n, .addr, .wdata, .wr,
  .rd, .rdata, .rxd0, .rxd1, .rx_done0, .rx_done1);
`default_nettype wire

// ==== verif/ufeam_node.sv ====
// Far-end serial node: sends one framed word on a line that idles high.
// Assumes the caller waits for send to return before the next word.
`default_nettype none
module ufeam_node #(
  parameter int DIV = 1
) (
  input  wire logic clk,
  output var  logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  // A bad stop bit is only a level; the line is always released high after.
  task automatic send(input logic nine, input logic [7:0] d, input logic b9, input logic stp);
    logic [11:0] f;
    f = nine ? {1'b1, stp, b9, d, 1'b0} : {2'b11, stp, d, 1'b0};
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      line <= f[i];
      repeat (16 * DIV - 1) @(posedge clk);
    end
  endtask
endmodule // ufeam_node
`default_nettype wire

// ==== verif/ufeam_tb.sv ====
// Bench for ufeam_top: register port, framing error and address match.
// Assumes two ufeam_node models drive the serial inputs.
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t got %h", $time, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  a;
  logic [31:0] r;
  logic [7:0]  cn [4] = '{8'hF0, 8'hF1, 8'hF2, 8'hFF};
  bit          hot;
  wire logic [7:0] rdata;
  wire logic   rxd0, rxd1, rx_done0, rx_done1;
  int          fails = 0;
  int          tests_run = 0;
  int          seed = 92;
  int          cyc = 0;
  always #12.5 clk = ~clk;
  ufeam_top #(.BROADCAST(1), .BAUD_DIV(16'd1)) u_dut (.clk, .rst_n, .addr, .wdata, .wr,
    .rd, .rdata, .rxd0, .rxd1, .rx_done0, .rx_done1);
  ufeam_node u_n0 (.clk, .line(rxd0));
  ufeam_node u_n1 (.clk, .line(rxd1));
  task automatic wreg(input logic [7:0] x, d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= x;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    hot = 1'b1;
  endtask
  // A read straight after a write shares its edge, so the two strobes touch.
  task automatic rchk(input logic [7:0] x, e);
    if (!hot) @(posedge clk);
    hot = 1'b0;
    rd <= 1'b1;
    addr <= x;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk) `CHK(rdata, e)
  endtask
  function automatic logic hit(logic [7:0] x, o, m);
    return ((x ^ o) & m) == 8'h00 || (x & (o | m)) == (o | m);
  endfunction
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'hB9, 8'h00);
    rchk(8'hBA, 8'h00);
    rchk(8'h5E, 8'h00);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      wreg(8'hA9, r[7:0]);
      wreg(8'hAA, r[15:8]);
      wreg(8'hB9, r[23:16]);
      wreg(8'hBA, r[31:24]);
      rchk(8'hBA, r[31:24]);
      rchk(8'hB9, r[23:16]);
      rchk(8'hAA, r[15:8]);
      rchk(8'hA9, r[7:0]);
    end
    wreg(8'h98, 8'h10);
    u_n0.send(1'b0, 8'h3C, 1'b0, 1'b0);
    rchk(8'h99, 8'h3C);
    rchk(8'h98, 8'h11);
    wreg(8'h87, 8'h40);
    rchk(8'h87, 8'h40);
    rchk(8'h98, 8'h91);
    wreg(8'h98, 8'h90);
    u_n0.send(1'b0, 8'hA5, 1'b0, 1'b1);
    rchk(8'h98, 8'h95);
    wreg(8'h98, 8'h15);
    rchk(8'h98, 8'h15);
    u_n0.send(1'b0, 8'h66, 1'b0, 1'b0);
    rchk(8'h98, 8'h95);
    rchk(8'h99, 8'hA5);
    wreg(8'h87, 8'h00);
    rchk(8'h98, 8'h15);
    wreg(8'h98, 8'h30);
    u_n0.send(1'b0, 8'h77, 1'b0, 1'b0);
    `CHK(rx_done0, 1'b0)
    rchk(8'h99, 8'hA5);
    wreg(8'hAA, 8'hF0);
    wreg(8'hBA, 8'hFA);
    for (int i = 0; i < 12; i++) begin
      a = i < 4 ? cn[i] : 8'($random(seed));
      wreg(8'hC0, 8'hB0);
      u_n1.send(1'b1, a, 1'b1, 1'b1);
      `CHK(rx_done1, hit(a, 8'hF0, 8'hFA))
      if (hit(a, 8'hF0, 8'hFA)) rchk(8'hC1, a);
    end
    wreg(8'hC0, 8'hB0);
    u_n1.send(1'b1, 8'h5A, 1'b0, 1'b1);
    `CHK(rx_done1, 1'b0)
    wreg(8'hC0, 8'h90);
    u_n1.send(1'b1, 8'h5A, 1'b0, 1'b1);
    rchk(8'hC1, 8'h5A);
    test_done();
  end
endmodule // tb
`default_nettype wire
